// File: inc/inj_consts.svh
// Contract
// - all logic runs on one clock; durations counted against that clock
// - injector channel fires only while enabled; disabled after reset
// - manual mode fires one pulse of programmed length on fire request
// - next manual pulse needs fire request to drop and rise again
// - angle limit flag clear input clears that channel's angle limit flag
// - scheduled pulse ends at end angle; start placed earlier by length
// - started pulse runs exactly its length whatever the engine speed
// - end and limit angles use the same ticks as the tracker position
// - peak interval input times 64 gives 2 MHz peak current ticks
// - pulse length counted in 40 MHz ticks using low 24 bits
// - injector short clear input clears that channel's short flag
// - low-side PWM runs only while enabled; disabled after reset
// - low-side short clear input clears that channel's short flag
// - PWM period counted in 2 MHz ticks using low 20 bits
// - switch closes at period start, opens when width count expires
// - width 0 holds switch open; width at or above period holds closed
// - angle limit flag sets when crank position equals angle limit
// - injector open load flag follows the open load condition
// - injector short sets sticky flag and disables channel until cleared
// - low-side open load flag follows the open load condition
// - low-side short sets sticky flag and disables channel until cleared
// - at angle limit pulse activity stops and scheduler re-arms; code stops scheduled pulses only, manual pulses run on
// - length lowered below accumulated ends pulse; raised extends it
// - end moved back within history window fires late full pulse
`ifndef INJ_CONSTS_SVH
`define INJ_CONSTS_SVH

`define REF_CLK_HZ    200000000
`define FAST_TICK_HZ  40000000
`define SLOW_TICK_HZ  2000000
`define FAST_DIV      (`REF_CLK_HZ / `FAST_TICK_HZ)
`define SLOW_DIV      (`REF_CLK_HZ / `SLOW_TICK_HZ)
`define ANGLE_W       16
`define PERIOD_W      24
`define LEN_W         24
`define PWM_W         20
`define PEAK_SH       6
`define PEAK_W        14
`define RST_OFF       1'b0

`endif

// File: inc/inj_pkg.sv
`default_nettype none
`include "inj_consts.svh"

package inj_pkg;

    typedef struct packed {
        logic [`ANGLE_W-1:0]  crank_now;
        logic [`ANGLE_W-1:0]  cycle_len;
        logic [`ANGLE_W-1:0]  hist_ticks;
        logic [`PERIOD_W-1:0] tick_period;
    } crank_t;

    typedef struct packed {
        logic        inj_chan_enable;
        logic        inj_manual_select;
        logic        inj_fire_request;
        logic        angle_limit_flag_clear;
        logic        inj_short_clear;
        logic [15:0] pulse_end_angle;
        logic [15:0] angle_limit;
        logic [31:0] pulse_length;
    } inj_ctl_t;

    typedef struct packed {
        logic        ls_chan_enable;
        logic        ls_short_clear;
        logic [31:0] ls_cycle_ticks;
        logic [31:0] ls_on_ticks;
    } ls_ctl_t;

    typedef struct packed {
        logic angle_limit_flag;
        logic inj_open_load_flag;
        logic inj_shorted_flag;
    } inj_stat_t;

    typedef struct packed {
        logic ls_open_load_flag;
        logic ls_shorted_flag;
    } ls_stat_t;

    typedef enum logic [1:0] {
        S_WAIT  = 2'b00,
        S_FIRE  = 2'b01,
        S_SPENT = 2'b10
    } inj_state_t;

endpackage : inj_pkg
`default_nettype wire

// File: hw/ls_pwm_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "inj_consts.svh"

module ls_pwm_chan (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // control
    input  wire inj_pkg::ls_ctl_t ctl,
    input  wire logic          slow_tick,
    // power stage sense
    input  wire logic          open_sense,
    input  wire logic          short_sense,
    // outputs
    output var  logic          drive_reg,
    output var  inj_pkg::ls_stat_t stat_reg
);
    import inj_pkg::*;

    logic [`PWM_W-1:0] cnt_reg;
    logic [`PWM_W-1:0] cnt_next;
    logic              shorted_next;
    logic              drive_next;

    wire [`PWM_W-1:0] per   = ctl.ls_cycle_ticks[`PWM_W-1:0];
    wire [`PWM_W-1:0] width = ctl.ls_on_ticks[`PWM_W-1:0];
    wire wrap   = (cnt_reg >= per - `PWM_W'(1)) || (per == '0);
    wire closed = (width != '0) &&
                  ((width >= per) || (cnt_reg < width));

    // counter held at zero while disabled so a new enable starts a fresh period
    assign cnt_next = !ctl.ls_chan_enable ? '0 :
                      !slow_tick ? cnt_reg :
                      wrap ? '0 : cnt_reg + `PWM_W'(1);

    // a short arriving with the clear wins
    assign shorted_next = short_sense ||
        (stat_reg.ls_shorted_flag && !ctl.ls_short_clear);

    assign drive_next = ctl.ls_chan_enable && closed &&
                        !shorted_next;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg   <= '0;
            drive_reg <= `RST_OFF;
            stat_reg  <= '0;
        end else begin
            cnt_reg                    <= cnt_next;
            drive_reg                  <= drive_next;
            stat_reg.ls_open_load_flag <= open_sense;
            stat_reg.ls_shorted_flag   <= shorted_next;
        end
    end

endmodule : ls_pwm_chan
`default_nettype wire

// File: hw/inj_ls_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "inj_consts.svh"

module inj_ls_ctrl #(
    parameter int NCH = 4
) (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    // crank position tracker
    input  wire inj_pkg::crank_t            crank_tracker_bundle,
    // injector control
    input  wire inj_pkg::inj_ctl_t [NCH-1:0] inj_control_group,
    input  wire logic [7:0]                 peak_interval,
    // low-side control
    input  wire inj_pkg::ls_ctl_t [NCH-1:0] ls_control_group,
    // power stage sense
    input  wire logic [NCH-1:0]             inj_open_sense,
    input  wire logic [NCH-1:0]             inj_short_sense,
    input  wire logic [NCH-1:0]             ls_open_sense,
    input  wire logic [NCH-1:0]             ls_short_sense,
    input  wire logic                       card_sense,
    // injector outputs
    output var  logic [NCH-1:0]             inj_drive,
    output var  logic [`PEAK_W-1:0]         inj_peak_ticks,
    output var  inj_pkg::inj_stat_t [NCH-1:0] inj_status_group,
    // low-side outputs
    output var  logic [NCH-1:0]             ls_drive,
    output var  inj_pkg::ls_stat_t [NCH-1:0] ls_status_group,
    // presence
    output var  logic                       card_detected
);
    import inj_pkg::*;

    localparam int FDIV = `FAST_DIV;
    localparam int SDIV = `SLOW_DIV;

    // forward distance from b to a around the engine cycle
    function automatic logic [`ANGLE_W-1:0] ang_dist(
        input logic [`ANGLE_W-1:0] a,
        input logic [`ANGLE_W-1:0] b,
        input logic [`ANGLE_W-1:0] cyc
    );
        ang_dist = (a >= b) ? a - b : a + cyc - b;
    endfunction : ang_dist

    // tick strobes derived from the single reference clock
    logic [7:0] fdiv_reg;
    logic [7:0] sdiv_reg;
    logic [7:0] fdiv_next;
    logic [7:0] sdiv_next;
    logic       fast_tick;
    logic       slow_tick;

    assign fast_tick = (fdiv_reg == 8'(FDIV - 1));
    assign slow_tick = (sdiv_reg == 8'(SDIV - 1));
    assign fdiv_next = fast_tick ? 8'h00 : fdiv_reg + 8'h01;
    assign sdiv_next = slow_tick ? 8'h00 : sdiv_reg + 8'h01;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fdiv_reg <= 8'h00;
            sdiv_reg <= 8'h00;
        end else begin
            fdiv_reg <= fdiv_next;
            sdiv_reg <= sdiv_next;
        end
    end

    // injector channel state
    inj_state_t            st_reg     [NCH];
    inj_state_t            st_next    [NCH];
    logic [`LEN_W-1:0]     acc_reg    [NCH];
    logic [`LEN_W-1:0]     acc_next   [NCH];
    logic [NCH-1:0]        fire_prev_reg;
    logic [NCH-1:0]        drive_next;
    logic [NCH-1:0]        limit_next;
    logic [NCH-1:0]        short_next;
    logic [NCH-1:0]        at_limit;
    logic [NCH-1:0]        due;
    logic [NCH-1:0]        fire_edge;
    logic [NCH-1:0]        len_done;
    logic [`LEN_W-1:0]     len        [NCH];

    // angle decode per channel
    always_comb begin
        logic [`ANGLE_W-1:0] ahead;
        logic [`ANGLE_W-1:0] behind;
        logic [`ANGLE_W+`PERIOD_W-1:0] eta;
        ahead  = '0;
        behind = '0;
        eta    = '0;
        for (int i = 0; i < NCH; i++) begin
            len[i] = inj_control_group[i].pulse_length[`LEN_W-1:0];
            at_limit[i] = crank_tracker_bundle.crank_now ==
                          inj_control_group[i].angle_limit;
            ahead  = ang_dist(inj_control_group[i].pulse_end_angle,
                              crank_tracker_bundle.crank_now,
                              crank_tracker_bundle.cycle_len);
            behind = ang_dist(crank_tracker_bundle.crank_now,
                              inj_control_group[i].pulse_end_angle,
                              crank_tracker_bundle.cycle_len);
            // time left to the end angle at the current speed, in 40 MHz ticks
            eta = ahead * crank_tracker_bundle.tick_period;
            due[i] = (eta <= {{`ANGLE_W{1'b0}}, len[i]}) ||
                     (behind < crank_tracker_bundle.hist_ticks);
            fire_edge[i] = inj_control_group[i].inj_fire_request &&
                           !fire_prev_reg[i];
            len_done[i] = acc_reg[i] >= len[i];
        end
    end

    // channel sequencing
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            st_next[i]  = st_reg[i];
            acc_next[i] = acc_reg[i];
            case (st_reg[i])
                S_WAIT: begin
                    if (!inj_control_group[i].inj_chan_enable) begin
                        st_next[i] = S_WAIT;
                    end else if (inj_control_group[i].inj_manual_select) begin
                        if (fire_edge[i] && len[i] != '0) begin
                            st_next[i]  = S_FIRE;
                            acc_next[i] = '0;
                        end
                    end else if (due[i] && !at_limit[i] &&
                                 len[i] != '0) begin
                        st_next[i]  = S_FIRE;
                        acc_next[i] = '0;
                    end
                end
                S_FIRE: begin
                    if (!inj_control_group[i].inj_chan_enable) begin
                        st_next[i] = S_SPENT;
                    end else if (at_limit[i] &&
                        !inj_control_group[i].inj_manual_select) begin
                        st_next[i] = S_WAIT;
                    end else if (len_done[i]) begin
                        st_next[i] = inj_control_group[i].inj_manual_select ?
                                     S_WAIT : S_SPENT;
                    end else if (fast_tick) begin
                        acc_next[i] = acc_reg[i] + `LEN_W'(1);
                    end
                end
                S_SPENT: begin
                    // one pulse per engine cycle; re-armed at the angle limit
                    if (at_limit[i] ||
                        inj_control_group[i].inj_manual_select) begin
                        st_next[i] = S_WAIT;
                    end
                end
                default: begin
                    st_next[i] = S_WAIT;
                end
            endcase
        end
    end

    // flags and drive; a set in the same cycle as its clear wins
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            limit_next[i] = at_limit[i] ||
                (inj_status_group[i].angle_limit_flag &&
                 !inj_control_group[i].angle_limit_flag_clear);
            short_next[i] = inj_short_sense[i] ||
                (inj_status_group[i].inj_shorted_flag &&
                 !inj_control_group[i].inj_short_clear);
            drive_next[i] = (st_next[i] == S_FIRE) &&
                inj_control_group[i].inj_chan_enable &&
                !short_next[i];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                st_reg[i]  <= S_WAIT;
                acc_reg[i] <= '0;
            end
            fire_prev_reg    <= '0;
            inj_drive        <= '0;
            inj_status_group <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                st_reg[i]  <= st_next[i];
                acc_reg[i] <= acc_next[i];
                fire_prev_reg[i] <= inj_control_group[i].inj_fire_request;
                inj_drive[i] <= drive_next[i];
                inj_status_group[i].angle_limit_flag   <= limit_next[i];
                inj_status_group[i].inj_open_load_flag <=
                    inj_open_sense[i];
                inj_status_group[i].inj_shorted_flag   <= short_next[i];
            end
        end
    end

    // peak current interval handed to the power stage in 2 MHz ticks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inj_peak_ticks <= '0;
            card_detected  <= `RST_OFF;
        end else begin
            inj_peak_ticks <= {peak_interval, {`PEAK_SH{1'b0}}};
            card_detected  <= card_sense;
        end
    end

    // low-side PWM channels
    for (genvar g = 0; g < NCH; g++) begin : g_ls
        ls_pwm_chan u_ls (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .ctl         (ls_control_group[g]),
            .slow_tick   (slow_tick),
            .open_sense  (ls_open_sense[g]),
            .short_sense (ls_short_sense[g]),
            .drive_reg   (ls_drive[g]),
            .stat_reg    (ls_status_group[g])
        );
    end

endmodule : inj_ls_ctrl
`default_nettype wire

// File: bench/inj_ls_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "inj_consts.svh"

module inj_ls_ctrl_asserts #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic                         ref_clk,
    input wire logic                         rst,
    // watched inputs
    input wire inj_pkg::crank_t              crank_tracker_bundle,
    input wire inj_pkg::inj_ctl_t [NCH-1:0]  inj_control_group,
    input wire logic [7:0]                   peak_interval,
    input wire inj_pkg::ls_ctl_t [NCH-1:0]   ls_control_group,
    input wire logic [NCH-1:0]               inj_short_sense,
    input wire logic [NCH-1:0]               ls_short_sense,
    // watched outputs
    input wire logic [NCH-1:0]               inj_drive,
    input wire logic [`PEAK_W-1:0]           inj_peak_ticks,
    input wire inj_pkg::inj_stat_t [NCH-1:0] inj_status_group,
    input wire logic [NCH-1:0]               ls_drive,
    input wire inj_pkg::ls_stat_t [NCH-1:0]  ls_status_group
);
    import inj_pkg::*;
    inj_ctl_t c0;
    inj_ctl_t c1;
    ls_ctl_t  l2;
    assign c0 = inj_control_group[0];
    assign c1 = inj_control_group[1];
    assign l2 = ls_control_group[2];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_man_req;
        c0.inj_manual_select && c0.inj_chan_enable && !inj_drive[0]
        && $rose(c0.inj_fire_request) && c0.pulse_length[23:0] == 24'h00_0004
        && !inj_status_group[0].inj_shorted_flag && !inj_short_sense[0];
    endsequence
    // four fast ticks: strobe phase gives 17 to 21 clocks high; check accepts 14 to 23
    sequence s_man_pulse;
        inj_drive[0] [*8] ##1 inj_drive[0] [*6] ##[1:10] !inj_drive[0];
    endsequence

    chk_man_pulse: assert property (s_man_req |=> s_man_pulse)
        else $error("manual pulse length wrong");
    chk_man_rearm: assert property (
        c0.inj_manual_select && c0.inj_fire_request
        && $past(c0.inj_fire_request) && !inj_drive[0] |=> !inj_drive[0])
        else $error("held fire request gave another pulse");
    chk_peak_scale: assert property (
        !$past(rst) |-> inj_peak_ticks == {$past(peak_interval), 6'h00})
        else $error("peak ticks not interval times 64");
    chk_limit_set: assert property (
        crank_tracker_bundle.crank_now == c1.angle_limit
        |=> inj_status_group[1].angle_limit_flag)
        else $error("angle limit flag not set");
    chk_limit_clear: assert property (
        c1.angle_limit_flag_clear
        && crank_tracker_bundle.crank_now != c1.angle_limit
        |=> !inj_status_group[1].angle_limit_flag)
        else $error("angle limit flag not cleared");
    chk_inj_short_lock: assert property (
        inj_short_sense[0] || inj_status_group[0].inj_shorted_flag
        && !c0.inj_short_clear
        |=> inj_status_group[0].inj_shorted_flag && !inj_drive[0])
        else $error("injector short not latched");
    chk_inj_short_clr: assert property (
        c0.inj_short_clear && !inj_short_sense[0]
        |=> !inj_status_group[0].inj_shorted_flag)
        else $error("injector short not cleared");
    chk_ls_short_lock: assert property (
        ls_short_sense[2] || ls_status_group[2].ls_shorted_flag
        && !l2.ls_short_clear
        |=> ls_status_group[2].ls_shorted_flag && !ls_drive[2])
        else $error("low-side short not latched");
    chk_ls_short_clr: assert property (
        l2.ls_short_clear && !ls_short_sense[2]
        |=> !ls_status_group[2].ls_shorted_flag)
        else $error("low-side short not cleared");
    chk_ls_enable_gate: assert property (
        !l2.ls_chan_enable |=> !ls_drive[2])
        else $error("low-side drive while disabled");
    chk_inj_enable_gate: assert property (
        !c0.inj_chan_enable |=> !inj_drive[0])
        else $error("injector drive while disabled");
endmodule : inj_ls_ctrl_asserts
`default_nettype wire

// File: bench/stage_model.sv
`timescale 1ns/1ps
`default_nettype none

module stage_model #(
    parameter int NCH = 4
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // faults ordered by the bench: low half injector, high half low-side
    input  wire logic [2*NCH-1:0] open_fault,
    input  wire logic [2*NCH-1:0] short_fault,
    // towards the controller
    output var  inj_pkg::crank_t  crank_tracker_bundle,
    output var  logic [NCH-1:0]   inj_open_sense,
    output var  logic [NCH-1:0]   inj_short_sense,
    output var  logic [NCH-1:0]   ls_open_sense,
    output var  logic [NCH-1:0]   ls_short_sense
);
    import inj_pkg::*;
    logic [3:0]  sub_reg;
    logic [15:0] now_reg;
    // one tick per degree, ten clocks each: two fast ticks per angle tick
    assign crank_tracker_bundle = '{now_reg, 16'h0168, 16'h002D,
                                    24'h00_0002};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sub_reg <= 4'h0;
            now_reg <= 16'h0000;
        end else if (sub_reg == 4'h9) begin
            sub_reg <= 4'h0;
            now_reg <= (now_reg == 16'h0167) ? 16'h0000 : now_reg + 16'h0001;
        end else begin
            sub_reg <= sub_reg + 4'h1;
        end
    end
    // no sense filtering: a fault shows on the very next edge
    assign inj_open_sense  = open_fault[NCH-1:0];
    assign inj_short_sense = short_fault[NCH-1:0];
    assign ls_open_sense   = open_fault[2*NCH-1:NCH];
    assign ls_short_sense  = short_fault[2*NCH-1:NCH];
endmodule : stage_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "inj_consts.svh"

module testbench;
    import inj_pkg::*;
    localparam int NCH = 4;
    logic               ref_clk;
    logic               rst;
    crank_t             crank;
    inj_ctl_t [NCH-1:0] ictl;
    ls_ctl_t [NCH-1:0]  lctl;
    logic [7:0]         peak;
    logic [7:0]         open_f;
    logic [7:0]         short_f;
    logic [NCH-1:0]     i_op, i_sh, l_op, l_sh, inj_drive, ls_drive;
    logic [13:0]        pk;
    logic               card_s;
    logic               card;
    inj_stat_t [NCH-1:0] ist;
    ls_stat_t [NCH-1:0] lst;
    int                 n_errors = 0;
    int                 checks_done = 0;
    int                 n;
    int                 h;

    always #2.5 ref_clk = ~ref_clk;

    stage_model #(.NCH(NCH)) stage_model_i (.ref_clk(ref_clk), .rst(rst),
        .open_fault(open_f), .short_fault(short_f),
        .crank_tracker_bundle(crank), .inj_open_sense(i_op),
        .inj_short_sense(i_sh), .ls_open_sense(l_op), .ls_short_sense(l_sh));
    inj_ls_ctrl #(.NCH(NCH)) inj_ls_ctrl_i (.ref_clk(ref_clk), .rst(rst),
        .crank_tracker_bundle(crank), .inj_control_group(ictl),
        .peak_interval(peak), .ls_control_group(lctl), .inj_open_sense(i_op),
        .inj_short_sense(i_sh), .ls_open_sense(l_op), .ls_short_sense(l_sh),
        .card_sense(card_s), .inj_drive(inj_drive), .inj_peak_ticks(pk),
        .inj_status_group(ist), .ls_drive(ls_drive), .ls_status_group(lst),
        .card_detected(card));

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %0h want %0h", $time, got, exp);
        end
    endtask : cmp

    // 0..3 injector drive, 4..7 low-side drive, 8..11 angle limit flag
    function automatic logic probe(input int s);
        return s < 4 ? inj_drive[s] : s < 8 ? ls_drive[s-4]
                                            : ist[s-8].angle_limit_flag;
    endfunction : probe

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wait_for(input int s, input logic lvl, output int c);
        c = 0;
        do begin
            tick(1);
            c++;
        end while (probe(s) !== lvl && c < 6000);
        if (c >= 6000) begin
            n_errors++;
            $display("[ERR] %0t wait timed out", $time);
            complete_run();
        end
    endtask : wait_for

    task automatic count_hi(input int s, input int k, output int c);
        c = 0;
        repeat (k) begin
            tick(1);
            c += int'(probe(s) !== 1'b0);
        end
    endtask : count_hi

    initial begin
        ref_clk = 0;
        rst = 1;
        ictl = '0;
        lctl = '0;
        open_f = 8'h00;
        short_f = 8'h00;
        peak = 8'hFF;
        card_s = 1;
        ictl[0].inj_manual_select = 1;
        ictl[0].inj_fire_request = 1;
        ictl[0].pulse_length = 32'h0100_0004;
        ictl[1].pulse_end_angle = 16'h0064;
        ictl[1].angle_limit = 16'h00C8;
        ictl[1].pulse_length = 32'h0000_0028;
        lctl[2].ls_cycle_ticks = 32'h0010_0004;
        lctl[2].ls_on_ticks = 32'h0000_0001;
        repeat (4) @(posedge ref_clk);
        rst <= 0;
        tick(40);
        cmp(inj_drive, 0);
        cmp(ls_drive, 0);
        cmp(pk, 32'h0000_3FC0);
        cmp(card, 1); // presence mirrors sense
        ictl[0].inj_chan_enable <= 1;
        ictl[0].inj_fire_request <= 0;
        @(posedge ref_clk);
        ictl[0].inj_fire_request <= 1;
        wait_for(0, 1, n);
        cmp(n inside {[1:2]}, 1);
        wait_for(0, 0, n);
        cmp(n inside {[15:25]}, 1);
        count_hi(0, 60, n);
        cmp(n, 0);
        ictl[0].inj_fire_request <= 0;
        @(posedge ref_clk);
        ictl[0].inj_fire_request <= 1;
        wait_for(0, 1, n);
        cmp(n inside {[1:2]}, 1);
        wait_for(0, 0, n);
        ictl[1].inj_chan_enable <= 1;
        wait_for(1, 1, n);
        cmp(crank.crank_now inside {[79:81]}, 1);
        wait_for(1, 0, n);
        cmp(n inside {[195:206]}, 1);
        cmp(crank.crank_now inside {[99:101]}, 1);
        wait_for(9, 1, n);
        cmp(crank.crank_now, 16'h00C8);
        ictl[1].angle_limit_flag_clear <= 1;
        tick(12);
        cmp(ist[1].angle_limit_flag, 0);
        ictl[1].angle_limit_flag_clear <= 0;
        for (int k = 2; k < 4; k++) begin
            ictl[k].pulse_length <= 32'h0000_0028;
            ictl[k].pulse_end_angle <= crank.crank_now
                                       - (k == 2 ? 16'h0050 : 16'h000A);
            ictl[k].angle_limit <= crank.crank_now + 16'h005A;
            ictl[k].inj_chan_enable <= 1;
        end
        wait_for(3, 1, n);
        cmp(n inside {[1:3]}, 1);
        cmp(inj_drive[2], 0);
        wait_for(3, 0, n);
        cmp(n inside {[195:206]}, 1);
        wait_for(1, 1, n);
        cmp(crank.crank_now inside {[79:81]}, 1);
        tick(50);
        ictl[1].pulse_length <= 32'h0000_0005;
        wait_for(1, 0, n);
        cmp(n inside {[1:3]}, 1);
        // a very long pulse on channel 2 must be cut at its angle limit
        ictl[2].pulse_length <= 32'h00FF_FFFF;
        short_f <= 8'h01;
        open_f <= 8'h41;
        tick(2);
        cmp(ist[0].inj_shorted_flag, 1);
        cmp(ist[0].inj_open_load_flag, 1);
        cmp(lst[2].ls_open_load_flag, 1);
        short_f <= 8'h00;
        open_f <= 8'h00;
        ictl[0].inj_fire_request <= 0;
        @(posedge ref_clk);
        ictl[0].inj_fire_request <= 1;
        count_hi(0, 30, n);
        cmp(n, 0);
        cmp(ist[0].inj_open_load_flag, 0);
        cmp(lst[2].ls_open_load_flag, 0);
        ictl[0].inj_short_clear <= 1;
        tick(2);
        cmp(ist[0].inj_shorted_flag, 0);
        lctl[2].ls_chan_enable <= 1;
        wait_for(6, 0, n);
        wait_for(6, 1, n);
        wait_for(6, 0, h);
        cmp(h inside {[99:101]}, 1);
        wait_for(6, 1, n);
        cmp(h + n inside {[399:401]}, 1);
        lctl[2].ls_on_ticks <= 32'h0000_0000;
        tick(2);
        count_hi(6, 450, n);
        cmp(n, 0);
        lctl[2].ls_on_ticks <= 32'h0000_0005;
        tick(2);
        count_hi(6, 450, n);
        cmp(n, 450);
        short_f <= 8'h40;
        tick(2);
        cmp(lst[2].ls_shorted_flag, 1);
        short_f <= 8'h00;
        count_hi(6, 20, n);
        cmp(n, 0);
        lctl[2].ls_short_clear <= 1;
        tick(3);
        cmp(ls_drive[2], 1);
        lctl[2].ls_chan_enable <= 0;
        tick(3);
        cmp(ls_drive[2], 0);
        cmp(inj_drive[2], 1);
        wait_for(2, 0, n);
        cmp(crank.crank_now, ictl[2].angle_limit);
        card_s <= 0;
        tick(2);
        cmp(card, 0); // presence mirrors sense
        complete_run();
    end
endmodule : testbench

bind inj_ls_ctrl inj_ls_ctrl_asserts #(.NCH(NCH)) chk_i (.ref_clk(ref_clk),
    .rst(rst), .crank_tracker_bundle(crank_tracker_bundle),
    .inj_control_group(inj_control_group), .peak_interval(peak_interval),
    .ls_control_group(ls_control_group), .inj_short_sense(inj_short_sense),
    .ls_short_sense(ls_short_sense), .inj_drive(inj_drive),
    .inj_peak_ticks(inj_peak_ticks), .inj_status_group(inj_status_group),
    .ls_drive(ls_drive), .ls_status_group(ls_status_group));
`default_nettype wire
